// ==== rtl/exec_pkg.sv ====
package exec_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_WORK = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_DATA_ADDR = 8'h0C;
    localparam logic [7:0] OFF_DATA_VAL = 8'h10;
    localparam logic [7:0] OFF_AUX_ADDR = 8'h14;
    localparam logic [7:0] OFF_AUX_VAL = 8'h18;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_BIT = 2;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_IMM_LSB = 16;
    localparam int ST_CARRY_BIT = 0;
    localparam int ST_NIBBLE_BIT = 1;
    localparam int ST_ZERO_BIT = 2;
    localparam int NIB_CARRY_BIT = 4;
    localparam int BYTE_CARRY_BIT = 8;

    localparam int DATA_DEPTH = 128;
    localparam int AUX_DEPTH = 32;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [4:0] AUX_RESET = 5'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OP_ROTATE_RIGHT,
        OP_SUB_BORROW_REG,
        OP_SUB_BORROW_IMM,
        OP_AUX_READ
    } op_t;
endpackage

// ==== rtl/alu_if.sv ====
interface alu_if;
    exec_pkg::op_t op;
    logic dest;
    logic [7:0] r_val;
    logic [7:0] imm;
    logic [7:0] work_val;
    logic [7:0] aux_val;
    logic c_in;
    logic dc_in;
    logic z_in;
    logic [7:0] result;
    logic to_data;
    logic c_out;
    logic dc_out;
    logic z_out;

    modport core (
        output op, dest, r_val, imm, work_val, aux_val, c_in, dc_in, z_in,
        input result, to_data, c_out, dc_out, z_out
    );
    modport unit (
        input op, dest, r_val, imm, work_val, aux_val, c_in, dc_in, z_in,
        output result, to_data, c_out, dc_out, z_out
    );
endinterface

// ==== rtl/exec_alu.sv ====
module exec_alu (
    alu_if.unit bus
);
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] left;

    // ------------------------------------------------------------
    // borrow arithmetic
    // ------------------------------------------------------------
    always_comb begin
        left = (bus.op == exec_pkg::OP_SUB_BORROW_IMM) ? bus.imm : bus.r_val;
        sum9 = {1'b0, left} + {1'b0, ~bus.work_val} + {8'h00, bus.c_in}; // RQ4 RQ6
        sum5 = {1'b0, left[3:0]} + {1'b0, ~bus.work_val[3:0]} + {4'h0, bus.c_in}; // RQ9
    end

    // ------------------------------------------------------------
    // result and flag selection
    // ------------------------------------------------------------
    always_comb begin
        bus.result = bus.r_val;
        bus.to_data = 1'b0;
        bus.c_out = bus.c_in;
        bus.dc_out = bus.dc_in;
        bus.z_out = bus.z_in;
        unique case (bus.op)
            exec_pkg::OP_ROTATE_RIGHT: begin
                bus.result = {bus.c_in, bus.r_val[7:1]}; // RQ1
                bus.c_out = bus.r_val[0]; // RQ3
                bus.to_data = bus.dest; // RQ2
            end
            exec_pkg::OP_SUB_BORROW_REG: begin
                bus.result = sum9[7:0]; // RQ4
                bus.c_out = sum9[exec_pkg::BYTE_CARRY_BIT]; // RQ5
                bus.dc_out = sum5[exec_pkg::NIB_CARRY_BIT]; // RQ9
                bus.z_out = (sum9[7:0] == exec_pkg::ZERO_BYTE); // RQ5
                bus.to_data = bus.dest; // RQ2
            end
            exec_pkg::OP_SUB_BORROW_IMM: begin
                bus.result = sum9[7:0]; // RQ6
                bus.c_out = sum9[exec_pkg::BYTE_CARRY_BIT]; // RQ7
                bus.dc_out = sum5[exec_pkg::NIB_CARRY_BIT]; // RQ9
                bus.z_out = (sum9[7:0] == exec_pkg::ZERO_BYTE); // RQ7
            end
            exec_pkg::OP_AUX_READ: begin
                bus.result = bus.aux_val; // RQ8
            end
        endcase
    end
endmodule

// ==== rtl/exec_core.sv ====
// How it works
// (RQ1) rotate right: carry into bit 7
// (RQ2) dest 0 to working, 1 to data
// (RQ3) old bit 0 to carry, only carry
// (RQ4) data plus inverted working plus carry
// (RQ5) carry means no borrow; zero flag
// (RQ6) immediate borrow-subtract always into working
// (RQ7) immediate form updates zero, nibble, carry
// (RQ8) aux page read into working, flags kept
// (RQ9) nibble carry is bit 3 carry-out
module exec_core (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    logic [7:0] data_mem [exec_pkg::DATA_DEPTH];
    logic [7:0] aux_mem [exec_pkg::AUX_DEPTH];
    logic [7:0] work_reg;
    logic carry_reg;
    logic nibble_carry_flag_reg;
    logic zero_reg;
    logic [6:0] data_addr_reg;
    logic [4:0] aux_addr_reg;
    logic [7:0] aw_addr_reg;
    logic aw_have_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_have_reg;
    logic wr_fire;
    logic wr_mapped;
    logic [31:0] wr_word;
    logic [6:0] cmd_addr;
    logic [31:0] rd_next;
    logic rd_mapped;
    logic do_cmd;

    alu_if alu_bus ();

    exec_alu alu_inst (
        .bus(alu_bus.unit)
    );

    // ------------------------------------------------------------
    // write channel capture
    // ------------------------------------------------------------
    assign wr_fire = aw_have_reg && w_have_reg && !BVALID;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            AWREADY <= 1'b1;
            aw_have_reg <= 1'b0;
            aw_addr_reg <= exec_pkg::ZERO_BYTE;
        end else if (CE) begin
            if (AWVALID && AWREADY) begin
                AWREADY <= 1'b0;
                aw_have_reg <= 1'b1;
                aw_addr_reg <= AWADDR;
            end else if (wr_fire) begin
                aw_have_reg <= 1'b0;
            end else if (BVALID && BREADY) begin
                AWREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            WREADY <= 1'b1;
            w_have_reg <= 1'b0;
            w_data_reg <= exec_pkg::ZERO_WORD;
            w_strb_reg <= 4'h0;
        end else if (CE) begin
            if (WVALID && WREADY) begin
                WREADY <= 1'b0;
                w_have_reg <= 1'b1;
                w_data_reg <= WDATA;
                w_strb_reg <= WSTRB;
            end else if (wr_fire) begin
                w_have_reg <= 1'b0;
            end else if (BVALID && BREADY) begin
                WREADY <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_word[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8] : exec_pkg::ZERO_BYTE;
        end
        unique case (aw_addr_reg)
            exec_pkg::OFF_CMD, exec_pkg::OFF_WORK, exec_pkg::OFF_STATUS, exec_pkg::OFF_DATA_ADDR,
            exec_pkg::OFF_DATA_VAL, exec_pkg::OFF_AUX_ADDR, exec_pkg::OFF_AUX_VAL: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    assign do_cmd = wr_fire && (aw_addr_reg == exec_pkg::OFF_CMD) && w_strb_reg[0];
    assign cmd_addr = wr_word[exec_pkg::CMD_ADDR_LSB +: 7];

    // ------------------------------------------------------------
    // operands to the execution unit
    // ------------------------------------------------------------
    assign alu_bus.op = exec_pkg::op_t'(wr_word[exec_pkg::CMD_OP_LSB +: 2]);
    assign alu_bus.dest = wr_word[exec_pkg::CMD_DEST_BIT];
    assign alu_bus.r_val = data_mem[cmd_addr];
    assign alu_bus.imm = wr_word[exec_pkg::CMD_IMM_LSB +: 8];
    assign alu_bus.work_val = work_reg;
    assign alu_bus.aux_val = aux_mem[cmd_addr[4:0]];
    assign alu_bus.c_in = carry_reg;
    assign alu_bus.dc_in = nibble_carry_flag_reg;
    assign alu_bus.z_in = zero_reg;

    // ------------------------------------------------------------
    // write response
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            BVALID <= 1'b0;
            BRESP <= exec_pkg::RESP_OKAY;
        end else if (CE) begin
            if (wr_fire) begin
                BVALID <= 1'b1;
                BRESP <= wr_mapped ? exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // working register and status flags
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            work_reg <= exec_pkg::WORK_RESET;
        end else if (CE) begin
            if (do_cmd && !alu_bus.to_data) begin
                work_reg <= alu_bus.result; // RQ2 RQ6 RQ8
            end else if (wr_fire && aw_addr_reg == exec_pkg::OFF_WORK && w_strb_reg[0]) begin
                work_reg <= w_data_reg[7:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            carry_reg <= 1'b0;
            nibble_carry_flag_reg <= 1'b0;
            zero_reg <= 1'b0;
        end else if (CE) begin
            if (do_cmd) begin
                carry_reg <= alu_bus.c_out; // RQ3 RQ5 RQ7
                nibble_carry_flag_reg <= alu_bus.dc_out; // RQ9
                zero_reg <= alu_bus.z_out; // RQ5 RQ7
            end else if (wr_fire && aw_addr_reg == exec_pkg::OFF_STATUS && w_strb_reg[0]) begin
                carry_reg <= w_data_reg[exec_pkg::ST_CARRY_BIT];
                nibble_carry_flag_reg <= w_data_reg[exec_pkg::ST_NIBBLE_BIT];
                zero_reg <= w_data_reg[exec_pkg::ST_ZERO_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // window address registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            data_addr_reg <= exec_pkg::ADDR_RESET;
            aux_addr_reg <= exec_pkg::AUX_RESET;
        end else if (CE && wr_fire && w_strb_reg[0]) begin
            if (aw_addr_reg == exec_pkg::OFF_DATA_ADDR) begin
                data_addr_reg <= w_data_reg[6:0];
            end
            if (aw_addr_reg == exec_pkg::OFF_AUX_ADDR) begin
                aux_addr_reg <= w_data_reg[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // data and auxiliary memories
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (CE) begin
            if (do_cmd && alu_bus.to_data) begin
                data_mem[cmd_addr] <= alu_bus.result; // RQ2
            end else if (wr_fire && aw_addr_reg == exec_pkg::OFF_DATA_VAL && w_strb_reg[0]) begin
                data_mem[data_addr_reg] <= w_data_reg[7:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (CE && wr_fire && aw_addr_reg == exec_pkg::OFF_AUX_VAL && w_strb_reg[0]) begin
            aux_mem[aux_addr_reg] <= w_data_reg[7:0];
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rd_next = exec_pkg::ZERO_WORD;
        rd_mapped = 1'b1;
        unique case (ARADDR)
            exec_pkg::OFF_CMD: rd_next = exec_pkg::ZERO_WORD;
            exec_pkg::OFF_WORK: rd_next[7:0] = work_reg;
            exec_pkg::OFF_STATUS: begin
                rd_next[exec_pkg::ST_CARRY_BIT] = carry_reg;
                rd_next[exec_pkg::ST_NIBBLE_BIT] = nibble_carry_flag_reg;
                rd_next[exec_pkg::ST_ZERO_BIT] = zero_reg;
            end
            exec_pkg::OFF_DATA_ADDR: rd_next[6:0] = data_addr_reg;
            exec_pkg::OFF_DATA_VAL: rd_next[7:0] = data_mem[data_addr_reg];
            exec_pkg::OFF_AUX_ADDR: rd_next[4:0] = aux_addr_reg;
            exec_pkg::OFF_AUX_VAL: rd_next[7:0] = aux_mem[aux_addr_reg];
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= exec_pkg::ZERO_WORD;
            RRESP <= exec_pkg::RESP_OKAY;
        end else if (CE) begin
            if (ARVALID && ARREADY) begin
                ARREADY <= 1'b0;
                RVALID <= 1'b1;
                RDATA <= rd_next;
                RRESP <= rd_mapped ? exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
                ARREADY <= 1'b1;
            end
        end
    end
endmodule

// ==== tb/exec_core_sva.sv ====
module exec_core_chk (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    input wire logic RREADY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (RST || !CE);

    property p_b_lat;
        AWVALID && AWREADY && WVALID && WREADY |=> !BVALID ##1 BVALID;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer not two cycles after handshake");
    property p_b_hold;
        BVALID && !BREADY |=> BVALID && $stable(BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
    property p_b_drop;
        BVALID && BREADY |=> !BVALID && AWREADY && WREADY;
    endproperty
    a_b_drop: assert property (p_b_drop) else $error("write slot not freed after answer");
    property p_r_lat;
        ARVALID && ARREADY |=> RVALID && !ARREADY;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer not one cycle after request");
    property p_r_hold;
        RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer changed while pending");
    property p_r_drop;
        RVALID && RREADY |=> !RVALID && ARREADY;
    endproperty
    a_r_drop: assert property (p_r_drop) else $error("read slot not freed after answer");
    property p_upper;
        RVALID |-> RDATA[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits not zero");
    property p_err_zero;
        RVALID && RRESP == exec_pkg::RESP_SLVERR |-> RDATA == exec_pkg::ZERO_WORD;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read carries data");
endmodule

bind exec_core exec_core_chk i_chk (.SYS_CLK, .RST, .CE, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);

// ==== tb/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
        $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
    logic SYS_CLK = 1'b0, RST = 1'b1, CE = 1'b1;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h00000000, RDATA;
    logic [3:0] WSTRB = 4'hF;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0] BRESP, RRESP;
    int error_cnt = 0;
    int n_tests = 0;
    // cycles with bvalid or rvalid seen before the bench raises its ready
    int stall = 0;

    exec_core i_exec_core (.SYS_CLK, .RST, .CE, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
        .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);

    always #5 SYS_CLK = ~SYS_CLK;

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = stall;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= (n == 0);
        do begin
            @(posedge SYS_CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
            if (BVALID === 1'b1 && n > 0) n--;
            if (n == 0 && !BREADY) BREADY <= 1'b1;
        end while (!(BVALID === 1'b1 && BREADY === 1'b1));
        BREADY <= 1'b0;
        `CHK(BRESP, er)
        @(posedge SYS_CLK);
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, exec_pkg::RESP_OKAY);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = stall;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= (n == 0);
        do begin
            @(posedge SYS_CLK);
            if (ARREADY) ARVALID <= 1'b0;
            if (RVALID === 1'b1 && n > 0) n--;
            if (n == 0 && !RREADY) RREADY <= 1'b1;
        end while (!(RVALID === 1'b1 && RREADY === 1'b1));
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
        @(posedge SYS_CLK);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK(d, e)
        `CHK(r, exec_pkg::RESP_OKAY)
    endtask

    task automatic put_data(input logic [6:0] i, input logic [7:0] v);
        wr_ok(exec_pkg::OFF_DATA_ADDR, {25'h0, i});
        wr_ok(exec_pkg::OFF_DATA_VAL, {24'h0, v});
    endtask

    task automatic chk_data(input logic [6:0] i, input logic [7:0] e);
        wr_ok(exec_pkg::OFF_DATA_ADDR, {25'h0, i});
        chk_rd(exec_pkg::OFF_DATA_VAL, {24'h0, e});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_bus;
        logic [31:0] d;
        logic [1:0] r;
        chk_rd(exec_pkg::OFF_WORK, 32'h00000000);
        chk_rd(exec_pkg::OFF_STATUS, 32'h00000000);
        chk_rd(exec_pkg::OFF_CMD, 32'h00000000);
        rd(8'h1C, d, r);
        `CHK(r, exec_pkg::RESP_SLVERR)
        `CHK(d, exec_pkg::ZERO_WORD)
        wr(8'h1C, 32'h000000FF, exec_pkg::RESP_SLVERR);
        // slow ready on both answers, then a write with the low lane off
        stall = 2;
        wr_ok(exec_pkg::OFF_WORK, 32'h0000005A);
        chk_rd(exec_pkg::OFF_WORK, 32'h0000005A);
        stall = 0;
        WSTRB <= 4'hE;
        wr_ok(exec_pkg::OFF_WORK, 32'h000000FF);
        WSTRB <= 4'hF;
        chk_rd(exec_pkg::OFF_WORK, 32'h0000005A);
    endtask

    task automatic t_rotate;
        put_data(7'h7F, 8'hA5);
        wr_ok(exec_pkg::OFF_STATUS, 32'h00000006);
        wr_ok(exec_pkg::OFF_CMD, 32'h00007F04);
        chk_data(7'h7F, 8'h52);
        chk_rd(exec_pkg::OFF_STATUS, 32'h00000007);
        wr_ok(exec_pkg::OFF_WORK, 32'h00000011);
        wr_ok(exec_pkg::OFF_CMD, 32'h00007F00);
        chk_rd(exec_pkg::OFF_WORK, 32'h000000A9);
        chk_data(7'h7F, 8'h52);
        chk_rd(exec_pkg::OFF_STATUS, 32'h00000006);
    endtask

    // register and immediate forms; odd cases carry in and, in the register form, pick the data register
    task automatic t_sub;
        logic [7:0] xs [5];
        logic [7:0] ws [5];
        logic [8:0] sum;
        logic [4:0] lo;
        logic c;
        xs = '{8'h05, 8'h05, 8'h06, 8'h06, 8'h10};
        ws = '{8'h06, 8'h06, 8'h05, 8'h05, 8'h01};
        for (int op = 1; op <= 2; op++) begin
            for (int i = 0; i < 5; i++) begin
                c = 1'(i % 2);
                sum = {1'b0, xs[i]} + {1'b0, ~ws[i]} + {8'h00, c};
                lo = {1'b0, xs[i][3:0]} + {1'b0, ~ws[i][3:0]} + {4'h0, c};
                put_data(7'h05, xs[i]);
                wr_ok(exec_pkg::OFF_WORK, {24'h0, ws[i]});
                wr_ok(exec_pkg::OFF_STATUS, {31'h0, c});
                wr_ok(exec_pkg::OFF_CMD, {8'h00, xs[i], 1'b0, 7'h05, 5'h00, c, 2'(op)});
                if (op == 2 || !c) begin
                    chk_rd(exec_pkg::OFF_WORK, {24'h0, sum[7:0]});
                    chk_data(7'h05, xs[i]);
                end else begin
                    chk_rd(exec_pkg::OFF_WORK, {24'h0, ws[i]});
                    chk_data(7'h05, sum[7:0]);
                end
                chk_rd(exec_pkg::OFF_STATUS, {29'h0, sum[7:0] == 8'h00, lo[4], sum[8]});
            end
        end
    endtask

    task automatic t_aux;
        wr_ok(exec_pkg::OFF_AUX_ADDR, 32'h0000001F);
        wr_ok(exec_pkg::OFF_AUX_VAL, 32'h0000003C);
        wr_ok(exec_pkg::OFF_AUX_ADDR, 32'h00000000);
        wr_ok(exec_pkg::OFF_AUX_VAL, 32'h000000C3);
        wr_ok(exec_pkg::OFF_STATUS, 32'h00000005);
        wr_ok(exec_pkg::OFF_CMD, 32'h00001F07);
        chk_rd(exec_pkg::OFF_WORK, 32'h0000003C);
        chk_rd(exec_pkg::OFF_STATUS, 32'h00000005);
        wr_ok(exec_pkg::OFF_CMD, 32'h00000003);
        chk_rd(exec_pkg::OFF_WORK, 32'h000000C3);
        chk_rd(exec_pkg::OFF_AUX_VAL, 32'h000000C3);
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        t_bus();
        t_rotate();
        t_sub();
        t_aux();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge SYS_CLK);
        error_cnt++;
        report_and_stop();
    end
endmodule
